// ---- logic/alert_regs_map.svh ----
// Purpose: offsets, field positions, resets and timing for the alert/timer register slice
// Assumes: 40 MHz clock
// Notes: definitions only
`ifndef ALERT_REGS_MAP_SVH
`define ALERT_REGS_MAP_SVH
`define OFF_ALERT_MASK_SECOND 8'h75
`define OFF_VOLTAGE_LOW_BITS 8'h76
`define OFF_TEMPERATURE_LOW_BITS 8'h77
`define OFF_THIRD_CONFIGURATION 8'h78
`define OFF_OVERHEAT_TIMER_STATUS 8'h79
`define RST_ALERT_MASK_SECOND 8'h00
`define RST_THIRD_CONFIGURATION 8'h00
`define RST_OVERHEAT_TIMER_STATUS 8'h00
`define MASK2_WRITABLE 8'hfc
`define BIT_OVERTEMP_MASK 1
`define BIT_FAN_MASK_LO 2
`define BIT_FOURTH_MASK 5
`define BIT_DIODE_MASK_LO 6
`define BIT_ALERT_ENABLE 0
`define BIT_TIMER_ENABLE 1
`define BIT_BOOST 2
`define BIT_FAST 3
`define BIT_CONT_LO 4
`define BIT_GATE_OOL 7
`define STEP_NS 22760000
`define CLK_PERIOD_NS 25
`define STEP_CYCLES (`STEP_NS / `CLK_PERIOD_NS)
`define LIMIT_ZERO 8'h00
`define PIN_FUNC_OVERHEAT 2'h1
`endif

// ---- logic/alert_pkg.sv ----
// Purpose: shared types for the alert/timer register slice
// Assumes: nothing
// Notes: constants live in alert_regs_map.svh
package alert_pkg;
   typedef enum logic [2:0] {
      T_IDLE = 3'h1,
      T_RUN = 3'h2,
      T_HOLD = 3'h4
   } timer_state_e;
endpackage : alert_pkg

// ---- logic/freeze_if.sv ----
// Purpose: carries the freeze handshake between the register file and the capture unit
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
interface freeze_if;
   logic freezeSet;
   logic freezeClear;
   logic frozen;
   modport ctrl (output freezeSet, output freezeClear, input frozen);
   modport unit (input freezeSet, input freezeClear, output frozen);
endinterface : freeze_if

// ---- logic/reading_freeze.sv ----
// Purpose: holds 10-bit readings, frozen between low-bit read and high-byte read
// Assumes: readings synchronous to clock
// Notes: freeze is set on low-bit read, cleared by high-byte read
`timescale 1ns/1ps
module reading_freeze #(
   parameter int CHANNELS = 2
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Live and held readings
   input wire logic [CHANNELS*10-1:0] live,
   output logic [CHANNELS*10-1:0] held,
   // Freeze control
   freeze_if.unit fz
);
   // R7: hold while frozen
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         held <= '0;
      end else if (!fz.frozen) begin
         held <= live;
      end
   end
   // Set wins over clear so a fresh low-bit read is never lost
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         fz.frozen <= 1'b0;
      end else if (fz.freezeSet) begin
         fz.frozen <= 1'b1;
      end else if (fz.freezeClear) begin
         fz.frozen <= 1'b0;
      end
   end
   // R7: no update while frozen
   chk_frozen_holds: assert property (@(posedge clock) disable iff (sys_rst) // R7
      fz.frozen && !fz.freezeClear |=> $stable(held))
      else $error("held reading changed while frozen");
endmodule : reading_freeze

// ---- logic/overheat_timer.sv ----
// Purpose: times overheat input assertion in 22.76 ms steps
// Assumes: input already synchronous
// Notes: count saturates at all ones
`timescale 1ns/1ps
`include "alert_regs_map.svh"
module overheat_timer
   import alert_pkg::*;
#(
   parameter int STEP_CYCLES = `STEP_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Control
   input wire logic enable,
   input wire logic overheatActive,
   // Result
   output logic [7:0] duration,
   output logic assertPulse
);
   timer_state_e state;
   logic [31:0] stepCount;
   logic lastActive;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         lastActive <= 1'b0;
      end else begin
         lastActive <= overheatActive && enable;
      end
   end
   assign assertPulse = overheatActive && enable && !lastActive;
   // R16: step counter per 22.76 ms
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state <= T_IDLE;
         stepCount <= '0;
         duration <= 8'h00;
      end else begin
         unique case (state)
            T_IDLE: begin
               stepCount <= '0;
               if (assertPulse) begin
                  duration <= 8'h00;
                  state <= T_RUN;
               end
            end
            T_RUN: begin
               if (!(overheatActive && enable)) begin
                  state <= T_HOLD;
               end else if (stepCount == 32'(STEP_CYCLES - 1)) begin
                  stepCount <= '0;
                  if (duration != 8'hff) begin
                     duration <= duration + 8'h01;
                  end
               end else begin
                  stepCount <= stepCount + 32'h1;
               end
            end
            T_HOLD: begin
               stepCount <= '0;
               if (assertPulse) begin
                  duration <= 8'h00;
                  state <= T_RUN;
               end
            end
         endcase
      end
   end
endmodule : overheat_timer

// ---- logic/alert_mask_overheat_timer_regs.sv ----
// Purpose: alert mask 2, extended resolution, config 3 and overheat timer registers
// Assumes: register port is a simple synchronous read/write strobe interface
// Notes: read data and all outputs are registered
`timescale 1ns/1ps
`include "alert_regs_map.svh"

// What this block does
// R1: Overtemp mask bit 1 read-only, masks alert; here it stays 0, so overtemp reaches the alert unless the gate bit blocks it
// R2: Bits 2-4 mask fan 1-3 faults
// R3: Bit 5 masks fan4 or timer event
// R4: Bits 6-7 mask remote diode faults
// R5: Voltage low bits at 3:2 and 5:4
// R6: Temperature low bits at 3:2,5:4,7:6
// R7: Low-bit read freezes until high-byte read
// R8: Config bit 0 makes second_fan_fault_mask pin alert
// R9: Config bit 1 enables overheat timer
// R10: Boost drives fans max on overheat
// R11: Fast bit gives 250 ms tach rate
// R12: Bits 4-7 select continuous dc tach
// R13: Lock bit makes config read-only
// R14: Timer bit 0 set on assert, read-clears
// R15: Bits 7:1 zero until 45.52 ms
// R16: 8-bit count, 22.76 ms step
// R17: Timer limit exceeded sets fourth status
// R18: Gate bit blocks second-status alerts
// R19: Alert on any unmasked pending status
module alert_mask_overheat_timer_regs
   import alert_pkg::*;
#(
   parameter int STEP_CYCLES = `STEP_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   // Neighbouring registers
   input wire logic configLock,
   input wire logic secondStatusGate,
   input wire logic [1:0] sharedPinFunction,
   input wire logic [7:0] overheatDurationLimit,
   input wire logic highByteRead,
   // Measurement readings
   input wire logic [19:0] voltageReadings,
   input wire logic [29:0] temperatureReadings,
   output logic [15:0] voltageHigh,
   output logic [23:0] temperatureHigh,
   // Events
   input wire logic overheatPinIn,
   input wire logic overtempEvent,
   input wire logic [3:0] fanFault,
   input wire logic [1:0] diodeFault,
   input wire logic firstStatusAlert,
   // Outputs to fan and alert logic
   output logic alertOut,
   output logic alertPinMode,
   output logic fansToMax,
   output logic fastTach,
   output logic [3:0] continuousTach,
   output logic fourthOrTimerStatus
);
   logic [7:0] alertMaskSecond;
   logic [7:0] thirdConfiguration;
   logic [7:0] timerStatus;
   logic [19:0] voltageHeld;
   logic [29:0] temperatureHeld;
   logic [7:0] duration;
   logic assertPulse;
   logic timerMode;
   logic limitHit;
   logic overtempLatched;
   logic [7:0] next_rdata;
   logic pendingUnmasked;
   freeze_if voltFz ();
   freeze_if tempFz ();

   ////////////////////////////////////////////////////////////////////////////
   // Freeze of the 10-bit readings
   // R7: freeze on low-bit read
   assign voltFz.freezeSet = regRead && regAddr == `OFF_VOLTAGE_LOW_BITS;
   assign voltFz.freezeClear = highByteRead;
   assign tempFz.freezeSet = regRead && regAddr == `OFF_TEMPERATURE_LOW_BITS;
   assign tempFz.freezeClear = highByteRead;

   reading_freeze #(.CHANNELS(2)) voltFreeze (
      .clock(clock),
      .sys_rst(sys_rst),
      .live(voltageReadings),
      .held(voltageHeld),
      .fz(voltFz.unit)
   );
   reading_freeze #(.CHANNELS(3)) tempFreeze (
      .clock(clock),
      .sys_rst(sys_rst),
      .live(temperatureReadings),
      .held(temperatureHeld),
      .fz(tempFz.unit)
   );

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         voltageHigh <= '0;
         temperatureHigh <= '0;
      end else begin
         voltageHigh <= {voltageHeld[19:12], voltageHeld[9:2]};
         temperatureHigh <= {temperatureHeld[29:22], temperatureHeld[19:12], temperatureHeld[9:2]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writable registers
   // R1: overtemp mask bit not writable
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         alertMaskSecond <= `RST_ALERT_MASK_SECOND;
      end else if (regWrite && regAddr == `OFF_ALERT_MASK_SECOND) begin
         alertMaskSecond <= regWdata & `MASK2_WRITABLE;
      end
   end

   // R13: locked config ignores writes
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         thirdConfiguration <= `RST_THIRD_CONFIGURATION;
      end else if (regWrite && regAddr == `OFF_THIRD_CONFIGURATION && !configLock) begin
         thirdConfiguration <= regWdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overheat timer
   // R9: timer needs enable and pin function
   assign timerMode = thirdConfiguration[`BIT_TIMER_ENABLE] && sharedPinFunction == `PIN_FUNC_OVERHEAT;

   overheat_timer #(.STEP_CYCLES(STEP_CYCLES)) timer (
      .clock(clock),
      .sys_rst(sys_rst),
      .enable(timerMode),
      .overheatActive(overheatPinIn),
      .duration(duration),
      .assertPulse(assertPulse)
   );

   // R14: set on assert, clear on read; set wins
   // R15: upper bits zero until two steps
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         timerStatus <= `RST_OVERHEAT_TIMER_STATUS;
      end else if (assertPulse) begin
         timerStatus <= 8'h01;
      end else if (duration >= 8'h02 && timerMode && overheatPinIn) begin
         // Count copied only while asserted, so a read after release still clears
         timerStatus <= duration;
      end else if (regRead && regAddr == `OFF_OVERHEAT_TIMER_STATUS) begin
         timerStatus <= 8'h00;
      end
   end

   // R17: limit zero trips on assertion
   assign limitHit = timerMode && ((overheatDurationLimit == `LIMIT_ZERO && assertPulse)
      || (overheatDurationLimit != `LIMIT_ZERO && duration > overheatDurationLimit));

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         fourthOrTimerStatus <= 1'b0;
         overtempLatched <= 1'b0;
      end else begin
         fourthOrTimerStatus <= limitHit || (!timerMode && fanFault[3]);
         overtempLatched <= overtempEvent;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alert combining
   // R2: fan masks
   // R3: fourth fan or timer mask
   // R4: diode masks
   // R18: second-status gate
   // R19: any unmasked pending
   always_comb begin
      pendingUnmasked = 1'b0;
      if (!secondStatusGate) begin
         pendingUnmasked = (overtempLatched && !alertMaskSecond[`BIT_OVERTEMP_MASK])
            || |(fanFault[2:0] & ~alertMaskSecond[`BIT_FAN_MASK_LO +: 3])
            || (fourthOrTimerStatus && !alertMaskSecond[`BIT_FOURTH_MASK])
            || |(diodeFault & ~alertMaskSecond[`BIT_DIODE_MASK_LO +: 2]);
      end
      pendingUnmasked = pendingUnmasked || firstStatusAlert;
   end

   // R8: alert pin mode
   // R10: boost on overheat
   // R11: fast tach
   // R12: continuous dc tach
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         alertOut <= 1'b0;
         alertPinMode <= 1'b0;
         fansToMax <= 1'b0;
         fastTach <= 1'b0;
         continuousTach <= 4'h0;
      end else begin
         alertOut <= pendingUnmasked && thirdConfiguration[`BIT_ALERT_ENABLE];
         alertPinMode <= thirdConfiguration[`BIT_ALERT_ENABLE];
         fansToMax <= thirdConfiguration[`BIT_BOOST] && sharedPinFunction == `PIN_FUNC_OVERHEAT && overheatPinIn;
         fastTach <= thirdConfiguration[`BIT_FAST];
         continuousTach <= thirdConfiguration[`BIT_CONT_LO +: 4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path
   // R5: voltage low bits
   // R6: temperature low bits
   always_comb begin
      next_rdata = 8'h00;
      unique case (regAddr)
         `OFF_ALERT_MASK_SECOND: next_rdata = alertMaskSecond;
         `OFF_VOLTAGE_LOW_BITS: next_rdata = {2'h0, voltageHeld[11:10], voltageHeld[1:0], 2'h0};
         `OFF_TEMPERATURE_LOW_BITS: next_rdata = {temperatureHeld[21:20], temperatureHeld[11:10],
            temperatureHeld[1:0], 2'h0};
         `OFF_THIRD_CONFIGURATION: next_rdata = thirdConfiguration;
         `OFF_OVERHEAT_TIMER_STATUS: next_rdata = timerStatus;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         regRdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_mask_bit_ro: assert property (@(posedge clock) disable iff (sys_rst) // R1
      alertMaskSecond[`BIT_OVERTEMP_MASK] == 1'b0)
      else $error("overtemp mask bit became set");
   chk_lock_blocks_write: assert property (@(posedge clock) disable iff (sys_rst) // R13
      configLock |=> $stable(thirdConfiguration))
      else $error("third configuration changed while locked");
   chk_assert_sets_flag: assert property (@(posedge clock) disable iff (sys_rst) // R14
      assertPulse |=> timerStatus == 8'h01)
      else $error("assert flag not set");
   chk_read_clears: assert property (@(posedge clock) disable iff (sys_rst) // R14
      regRead && regAddr == `OFF_OVERHEAT_TIMER_STATUS && !assertPulse
      && !(duration >= 8'h02 && timerMode && overheatPinIn) |=> timerStatus == 8'h00)
      else $error("timer status not cleared by read");
   chk_upper_zero: assert property (@(posedge clock) disable iff (sys_rst) // R15
      duration < 8'h02 |-> timerStatus[7:1] == 7'h00)
      else $error("timer upper bits set too early");
   chk_gate_blocks: assert property (@(posedge clock) disable iff (sys_rst) // R18
      secondStatusGate && !firstStatusAlert |=> !alertOut)
      else $error("alert despite gate");
   chk_alert_enable: assert property (@(posedge clock) disable iff (sys_rst) // R8
      !thirdConfiguration[`BIT_ALERT_ENABLE] |=> !alertOut)
      else $error("alert without pin enabled");
   chk_boost_max: assert property (@(posedge clock) disable iff (sys_rst) // R10
      thirdConfiguration[`BIT_BOOST] && sharedPinFunction == `PIN_FUNC_OVERHEAT && overheatPinIn |=> fansToMax)
      else $error("boost did not drive fans");
   chk_fast_follow: assert property (@(posedge clock) disable iff (sys_rst) // R11
      ##1 fastTach == $past(thirdConfiguration[`BIT_FAST]))
      else $error("fast tach not following config");
   chk_limit_zero: assert property (@(posedge clock) disable iff (sys_rst) // R17
      timerMode && overheatDurationLimit == `LIMIT_ZERO && assertPulse |=> fourthOrTimerStatus)
      else $error("zero limit did not trip");
   cov_timer_run: cover property (@(posedge clock) disable iff (sys_rst) duration == 8'h03);
   cov_freeze: cover property (@(posedge clock) disable iff (sys_rst) tempFz.freezeSet ##[1:20] highByteRead);
   cov_alert: cover property (@(posedge clock) disable iff (sys_rst) alertOut);
endmodule : alert_mask_overheat_timer_regs

// ---- sim/measurement_model.sv ----
// Purpose: far-side measurement engine feeding 10-bit readings
// Assumes: one sample step per newSample pulse
// Notes: every voltage step changes low and high bits alike; a temperature step can leave a channel's low bits unchanged
`timescale 1ns/1ps
module measurement_model (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Sample step
   input wire logic newSample,
   // Readings
   output logic [19:0] voltageReadings,
   output logic [29:0] temperatureReadings
);
   // Readings move only on request, so the bench knows what was sampled
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         voltageReadings <= 20'h5a3c1;
         temperatureReadings <= 30'h2b4d1e7;
      end else if (newSample) begin
         voltageReadings <= voltageReadings + 20'h3a5b7;
         temperatureReadings <= {temperatureReadings[28:0], temperatureReadings[29]} ^ 30'h1d5a3c6;
      end
   end
endmodule : measurement_model

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the alert mask, resolution, config and timer slice
// Assumes: STEP_CYCLES shortened to 4
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
`include "alert_regs_map.svh"
`define CHK_EQ(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module testbench;
   import alert_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, overheatDurationLimit = 8'h00, rv;
   logic configLock = 1'b0, secondStatusGate = 1'b0, highByteRead = 1'b0, newSample = 1'b0;
   logic [1:0] sharedPinFunction = 2'h0, diodeFault = 2'h0;
   logic [19:0] voltageReadings, v1;
   logic [29:0] temperatureReadings, t1;
   logic [15:0] voltageHigh;
   logic [23:0] temperatureHigh;
   logic overheatPinIn = 1'b0, overtempEvent = 1'b0, firstStatusAlert = 1'b0;
   logic [3:0] fanFault = 4'h0, continuousTach;
   logic alertOut, alertPinMode, fansToMax, fastTach, fourthOrTimerStatus;
   int n_tests = 0, n_mismatch = 0;
   always #12.5 clock = ~clock;
   measurement_model model_u (.clock(clock), .sys_rst(sys_rst), .newSample(newSample),
      .voltageReadings(voltageReadings), .temperatureReadings(temperatureReadings));
   alert_mask_overheat_timer_regs #(.STEP_CYCLES(4)) dut_u (.clock(clock), .sys_rst(sys_rst),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .configLock(configLock), .secondStatusGate(secondStatusGate), .sharedPinFunction(sharedPinFunction),
      .overheatDurationLimit(overheatDurationLimit), .highByteRead(highByteRead),
      .voltageReadings(voltageReadings), .temperatureReadings(temperatureReadings),
      .voltageHigh(voltageHigh), .temperatureHigh(temperatureHigh), .overheatPinIn(overheatPinIn),
      .overtempEvent(overtempEvent), .fanFault(fanFault), .diodeFault(diodeFault),
      .firstStatusAlert(firstStatusAlert), .alertOut(alertOut), .alertPinMode(alertPinMode),
      .fansToMax(fansToMax), .fastTach(fastTach), .continuousTach(continuousTach),
      .fourthOrTimerStatus(fourthOrTimerStatus));
   ////////////////////////////////////////////////////////////////////////////
   task automatic waitc(input int n);
      repeat (n) @(negedge clock);
   endtask : waitc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clock);
      regWrite = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clock);
      regRead = 1'b0;
      d = regRdata;
   endtask : rd
   task automatic pulse_sample();
      newSample = 1'b1;
      waitc(1);
      newSample = 1'b0;
      waitc(3);
   endtask : pulse_sample
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_and_mask();
      rd(`OFF_ALERT_MASK_SECOND, rv);
      `CHK_EQ("mask2 reset", `RST_ALERT_MASK_SECOND, rv)
      rd(`OFF_THIRD_CONFIGURATION, rv);
      `CHK_EQ("config3 reset", `RST_THIRD_CONFIGURATION, rv)
      rd(`OFF_OVERHEAT_TIMER_STATUS, rv);
      `CHK_EQ("timer reset", `RST_OVERHEAT_TIMER_STATUS, rv)
      wr(8'h7a, 8'hff);
      rd(8'h7a, rv);
      `CHK_EQ("unmapped", 8'h00, rv)
      wr(`OFF_ALERT_MASK_SECOND, 8'hff);
      rd(`OFF_ALERT_MASK_SECOND, rv);
      `CHK_EQ("mask2 read-only bit", 8'hfc, rv)
      wr(`OFF_ALERT_MASK_SECOND, 8'h00);
   endtask : t_reset_and_mask
   // Each fan and diode source raised alone, then masked by its own bit
   task automatic t_alert_masks();
      wr(`OFF_THIRD_CONFIGURATION, 8'h01);
      for (int i = 0; i < 6; i++) begin
         if (i < 4) fanFault[i] = 1'b1;
         else diodeFault[i-4] = 1'b1;
         waitc(3);
         `CHK_EQ("alert unmasked", 1'b1, alertOut)
         wr(`OFF_ALERT_MASK_SECOND, 8'h04 << ((i < 4) ? i : i + 0));
         waitc(3);
         `CHK_EQ("alert masked", 1'b0, alertOut)
         fanFault = 4'h0;
         diodeFault = 2'h0;
         wr(`OFF_ALERT_MASK_SECOND, 8'h00);
      end
      overtempEvent = 1'b1;
      wr(`OFF_ALERT_MASK_SECOND, 8'hff);
      waitc(3);
      `CHK_EQ("overtemp unmaskable", 1'b1, alertOut)
      overtempEvent = 1'b0;
      wr(`OFF_ALERT_MASK_SECOND, 8'h00);
      fanFault[0] = 1'b1;
      secondStatusGate = 1'b1;
      waitc(3);
      `CHK_EQ("gate blocks", 1'b0, alertOut)
      firstStatusAlert = 1'b1;
      waitc(3);
      `CHK_EQ("first status passes", 1'b1, alertOut)
      wr(`OFF_THIRD_CONFIGURATION, 8'h00);
      waitc(3);
      `CHK_EQ("alert disabled", 1'b0, alertOut)
      {fanFault, secondStatusGate, firstStatusAlert} = 6'h00;
   endtask : t_alert_masks
   task automatic t_config_lock();
      wr(`OFF_THIRD_CONFIGURATION, 8'hf9);
      waitc(2);
      `CHK_EQ("pin mode", 1'b1, alertPinMode)
      `CHK_EQ("fast tach", 1'b1, fastTach)
      `CHK_EQ("continuous tach", 4'hf, continuousTach)
      configLock = 1'b1;
      wr(`OFF_THIRD_CONFIGURATION, 8'h00);
      rd(`OFF_THIRD_CONFIGURATION, rv);
      `CHK_EQ("locked config", 8'hf9, rv)
      `CHK_EQ("locked outputs", 4'hf, continuousTach)
      configLock = 1'b0;
      wr(`OFF_THIRD_CONFIGURATION, 8'h00);
      waitc(2);
      `CHK_EQ("fast off", 1'b0, fastTach)
   endtask : t_config_lock
   // Low bits read freezes high bytes until a high-byte read
   task automatic t_freeze();
      pulse_sample();
      v1 = voltageReadings;
      t1 = temperatureReadings;
      rd(`OFF_TEMPERATURE_LOW_BITS, rv);
      `CHK_EQ("temp low bits", {t1[21:20], t1[11:10], t1[1:0], 2'b00}, rv & 8'hfc)
      rd(`OFF_VOLTAGE_LOW_BITS, rv);
      `CHK_EQ("volt low bits", {2'b00, v1[11:10], v1[1:0], 2'b00}, rv & 8'h3c)
      pulse_sample();
      `CHK_EQ("temp held", {t1[29:22], t1[19:12], t1[9:2]}, temperatureHigh)
      `CHK_EQ("volt held", {v1[19:12], v1[9:2]}, voltageHigh)
      highByteRead = 1'b1;
      waitc(1);
      highByteRead = 1'b0;
      waitc(3);
      t1 = temperatureReadings;
      `CHK_EQ("temp released", {t1[29:22], t1[19:12], t1[9:2]}, temperatureHigh)
      v1 = voltageReadings;
      `CHK_EQ("volt released", {v1[19:12], v1[9:2]}, voltageHigh)
   endtask : t_freeze
   task automatic overheat_for(input int n);
      overheatPinIn = 1'b1;
      waitc(n);
   endtask : overheat_for
   task automatic t_timer();
      sharedPinFunction = `PIN_FUNC_OVERHEAT;
      overheatDurationLimit = 8'h03;
      wr(`OFF_THIRD_CONFIGURATION, 8'h04);
      overheat_for(3);
      `CHK_EQ("boost without timer", 1'b1, fansToMax)
      overheatPinIn = 1'b0;
      waitc(2);
      rd(`OFF_OVERHEAT_TIMER_STATUS, rv);
      `CHK_EQ("timer disabled", 8'h00, rv)
      wr(`OFF_THIRD_CONFIGURATION, 8'h06);
      overheat_for(3);
      `CHK_EQ("boost", 1'b1, fansToMax)
      `CHK_EQ("below limit", 1'b0, fourthOrTimerStatus)
      overheatPinIn = 1'b0;
      waitc(2);
      rd(`OFF_OVERHEAT_TIMER_STATUS, rv);
      `CHK_EQ("asserted flag", 8'h01, rv)
      rd(`OFF_OVERHEAT_TIMER_STATUS, rv);
      `CHK_EQ("read clears", 8'h00, rv)
      overheatDurationLimit = `LIMIT_ZERO;
      overheat_for(1);
      `CHK_EQ("zero limit", 1'b1, fourthOrTimerStatus)
      waitc(2);
      overheatPinIn = 1'b0;
      waitc(2);
      overheatDurationLimit = 8'h03;
      rd(`OFF_OVERHEAT_TIMER_STATUS, rv);
      overheat_for(40);
      `CHK_EQ("limit exceeded", 1'b1, fourthOrTimerStatus)
      rd(`OFF_OVERHEAT_TIMER_STATUS, rv);
      `CHK_EQ("duration count", 1'b1, rv >= 8'h08 && rv <= 8'h0b)
      overheatPinIn = 1'b0;
      waitc(3);
      `CHK_EQ("boost off", 1'b0, fansToMax)
      rd(`OFF_OVERHEAT_TIMER_STATUS, rv);
      rd(`OFF_OVERHEAT_TIMER_STATUS, rv);
      `CHK_EQ("count read clears", 8'h00, rv)
   endtask : t_timer
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // Whole run is about 200 cycles, so 40000 leaves ample margin
   initial begin
      #(40000 * 25);
      n_mismatch++;
      $display("[FAIL] watchdog expected done seen hang");
      stop_test();
   end
   initial begin
      repeat (4) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      t_reset_and_mask();
      t_alert_masks();
      t_config_lock();
      t_freeze();
      t_timer();
      stop_test();
   end
endmodule : testbench
